// ==== rtl/tis_pkg.sv ====
`default_nettype none
package tis_pkg;
    // Store geometry
    localparam int STORE_DEPTH     = 100;
    localparam int CAM_DEPTH       = 50;
    localparam int IDX_W           = 7;
    localparam int BANK_W          = 5;
    localparam logic [4:0] BANK_MAX        = 5'h1f;
    localparam logic [4:0] BANK_RESET      = 5'h00;
    localparam logic [4:0] GROUP_RESET     = 5'h00;
    localparam logic [IDX_W-1:0] IDX_ZERO  = 7'h00;
    localparam logic [IDX_W-1:0] IDX_ONE   = 7'h01;
    // Init counter end value after reset; init lasts one cycle more, READY rises the cycle after
    localparam logic [3:0] INIT_CYCLES     = 4'h8;

    // Register offsets (word addresses on the plain port)
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_BANK   = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_COUNT  = 4'h3;
    localparam logic [3:0] REG_TIME0  = 4'h4;
    localparam logic [3:0] REG_TIME1  = 4'h5;
    localparam logic [3:0] REG_CLEAR  = 4'h6;
    localparam logic [3:0] REG_LASTIDX = 4'h7;

    // CTRL field positions
    localparam int CTRL_KEEP_LO   = 0;
    localparam int CTRL_CLR_BANK  = 2;
    localparam int CTRL_REJ_REP   = 3;
    localparam int CTRL_TWO_CAM   = 4;
    localparam logic [31:0] CTRL_RESET = 32'h0000000c;

    // Retention modes
    typedef enum logic [1:0] {
        KEEP_NONE        = 2'b00,
        keep_failed_only = 2'b01,
        KEEP_ALL         = 2'b10
    } tis_keep_t;

    // Measurement sequencer
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_IDLE = 2'b01,
        ST_MEAS = 2'b10
    } tis_state_t;

    // Software register port
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } tis_bus_t;

    // Calendar units
    typedef struct packed {
        logic [7:0] year;
        logic [7:0] month;
        logic [7:0] day;
        logic [7:0] hour;
        logic [7:0] minute;
        logic [7:0] second;
    } tis_cal_t;
endpackage
`default_nettype wire

// ==== rtl/tis_ring.sv ====
`timescale 1ns/1ns
`default_nettype none
module tis_ring #(
    parameter int DEPTH = 100,
    parameter int W     = 7
) (
    input  wire logic         clk,
    input  wire logic         rst_b,
    input  wire logic         clear,
    input  wire logic         push,
    input  wire logic [W-1:0] base,
    input  wire logic [W-1:0] limit,
    output logic [W-1:0]      count,
    output logic [W-1:0]      slot
);
    import tis_pkg::*;

    logic [W-1:0] wr_ptr;

    // Oldest-first overwrite within [base, base+limit)
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr <= '0;
            count  <= '0;
            slot   <= '0;
        end else if (clear) begin
            wr_ptr <= '0;
            count  <= '0;
        end else if (push) begin
            slot <= W'(base + wr_ptr);
            if (wr_ptr == W'(limit - IDX_ONE)) begin
                wr_ptr <= '0;
            end else begin
                wr_ptr <= W'(wr_ptr + IDX_ONE);
            end
            if (count != limit) begin
                count <= W'(count + IDX_ONE);
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/tis_ctrl.sv ====
// Summary of operation
// - Store holds 100 images, oldest overwritten
// - Two cameras: 50 images each, separately
// - Power loss empties the image store
// - Retention: none, failed only, or all
// - Bank change clears store unless disabled
// - Ready only when trigger or command accepted; CMD input is unused, so READY only marks idle for triggers
// - Trigger during measurement is ignored
// - Reporting off: error output stays low
// - Reporting on: busy trigger raises error
// - Error holds until next accepted trigger; the code also clears it as soon as reporting is turned off
// - Startup bank 0 to 31, default 0
// - Startup group nonzero needs card present
// - Clear request empties store, keeps settings
// - Calendar units separately settable
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module tis_ctrl #(
    parameter int STORE = 100,
    parameter int CAM   = 50
) (
    input  wire logic                  CLK,
    input  wire logic                  RST_B,
    input  wire tis_pkg::tis_bus_t     BUS,
    output logic [31:0]                RDATA,
    input  wire logic                  TRIG,
    input  wire logic                  CMD,
    input  wire logic                  MEAS_DONE,
    input  wire logic                  FAIL_VERDICT,
    input  wire logic                  MEAS_CAM,
    input  wire logic                  BANK_CHANGE,
    input  wire logic                  CARD_PRESENT,
    output logic                       READY,
    output logic                       TRIG_ERR,
    output logic                       MEAS_START,
    output logic                       IMG_WRITE,
    output logic [tis_pkg::IDX_W-1:0]  IMG_SLOT,
    output logic [tis_pkg::BANK_W-1:0] ACTIVE_BANK,
    output logic                       CARD_LOAD,
    output logic                       CARD_MISSING
);
    import tis_pkg::*;

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    tis_state_t        state;
    logic [31:0]       ctrl;
    logic [BANK_W-1:0] startup_bank;
    logic [BANK_W-1:0] startup_group;
    tis_cal_t          cal;
    logic [3:0]        init_cnt;
    logic              clear_req;
    logic              meas_cam;
    logic              keep_img;
    logic              store_clear;
    logic              trig_ok;
    logic              trig_busy;
    logic [IDX_W-1:0]  cnt0;
    logic [IDX_W-1:0]  cnt1;
    logic [IDX_W-1:0]  slot0;
    logic [IDX_W-1:0]  slot1;
    logic [IDX_W-1:0]  lim;
    logic              push0;
    logic              push1;
    logic              push_d;
    logic              cam_d;
    logic [1:0]        keep_mode;
    logic              two_cam;

    assign keep_mode = ctrl[CTRL_KEEP_LO+1:CTRL_KEEP_LO];
    assign two_cam   = ctrl[CTRL_TWO_CAM];

    // Register writes
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl          <= CTRL_RESET;
            startup_bank  <= BANK_RESET;
            startup_group <= GROUP_RESET;
        end else if (BUS.wr) begin
            if (BUS.addr == REG_CTRL) begin
                ctrl <= BUS.wdata;
            end else if (BUS.addr == REG_BANK) begin
                startup_bank  <= BUS.wdata[BANK_W-1:0];
                startup_group <= BUS.wdata[8+BANK_W-1:8];
            end
        end
    end

    // Calendar: each unit written by its own byte lane
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cal <= '0;
        end else if (BUS.wr && BUS.addr == REG_TIME0) begin
            if (BUS.wdata[24]) cal.second <= BUS.wdata[7:0];
            if (BUS.wdata[25]) cal.minute <= BUS.wdata[15:8];
            if (BUS.wdata[26]) cal.hour   <= BUS.wdata[23:16];
        end else if (BUS.wr && BUS.addr == REG_TIME1) begin
            if (BUS.wdata[24]) cal.day    <= BUS.wdata[7:0];
            if (BUS.wdata[25]) cal.month  <= BUS.wdata[15:8];
            if (BUS.wdata[26]) cal.year   <= BUS.wdata[23:16];
        end
    end

    // Clear request pulse
    assign clear_req = BUS.wr && (BUS.addr == REG_CLEAR) && BUS.wdata[0];

    // ------------------------------------------------------------
    // Measurement sequencer
    // ------------------------------------------------------------
    assign trig_ok   = TRIG && (state == ST_IDLE);
    assign trig_busy = TRIG && (state == ST_MEAS);

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state    <= ST_INIT;
            init_cnt <= '0;
            meas_cam <= 1'b0;
        end else begin
            case (state)
                ST_INIT: begin
                    // Hold ready low until init done
                    if (init_cnt == INIT_CYCLES) begin
                        state <= ST_IDLE;
                    end else begin
                        init_cnt <= init_cnt + 4'h1;
                    end
                end
                ST_IDLE: begin
                    if (trig_ok) begin
                        state    <= ST_MEAS;
                        meas_cam <= MEAS_CAM;
                    end
                end
                ST_MEAS: begin
                    // Busy triggers do not restart
                    if (MEAS_DONE) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_INIT;
                end
            endcase
        end
    end

    // Ready only when idle
    assign READY      = (state == ST_IDLE);
    assign MEAS_START = trig_ok;

    // Trigger error flag
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            TRIG_ERR <= 1'b0;
        end else if (trig_busy && ctrl[CTRL_REJ_REP]) begin
            TRIG_ERR <= 1'b1;
        end else if (!ctrl[CTRL_REJ_REP]) begin
            TRIG_ERR <= 1'b0;
        end else if (trig_ok) begin
            TRIG_ERR <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Image store
    // ------------------------------------------------------------
    always_comb begin
        case (keep_mode)
            keep_failed_only: keep_img = FAIL_VERDICT;
            KEEP_ALL:         keep_img = 1'b1;
            default:          keep_img = 1'b0;
        endcase
    end

    assign store_clear = clear_req
                       || (BANK_CHANGE && ctrl[CTRL_CLR_BANK]);
    assign push0 = (state == ST_MEAS) && MEAS_DONE && keep_img
                   && !(two_cam && meas_cam);
    assign push1 = (state == ST_MEAS) && MEAS_DONE && keep_img
                   && two_cam && meas_cam;
    assign lim   = two_cam ? IDX_W'(CAM) : IDX_W'(STORE);

    // Camera 0 ring (whole store in single-camera mode)
    tis_ring #(.DEPTH(STORE), .W(IDX_W)) u_ring0 (
        .clk   (CLK),
        .rst_b (RST_B),
        .clear (store_clear),
        .push  (push0),
        .base  (IDX_ZERO),
        .limit (lim),
        .count (cnt0),
        .slot  (slot0)
    );

    // Camera 1 ring, upper half of store
    tis_ring #(.DEPTH(CAM), .W(IDX_W)) u_ring1 (
        .clk   (CLK),
        .rst_b (RST_B),
        .clear (store_clear),
        .push  (push1),
        .base  (IDX_W'(CAM)),
        .limit (IDX_W'(CAM)),
        .count (cnt1),
        .slot  (slot1)
    );

    // Write strobe follows slot update
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            push_d <= 1'b0;
            cam_d  <= 1'b0;
        end else begin
            push_d <= push0 || push1;
            cam_d  <= push1;
        end
    end
    assign IMG_WRITE = push_d;
    assign IMG_SLOT  = cam_d ? slot1 : slot0;

    // ------------------------------------------------------------
    // Startup bank and card load
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ACTIVE_BANK  <= BANK_RESET;
            CARD_LOAD    <= 1'b0;
            CARD_MISSING <= 1'b0;
        end else if (state == ST_INIT && init_cnt == INIT_CYCLES) begin
            ACTIVE_BANK  <= startup_bank;
            CARD_LOAD    <= (startup_group != GROUP_RESET) && CARD_PRESENT;
            CARD_MISSING <= (startup_group != GROUP_RESET) && !CARD_PRESENT;
        end else begin
            CARD_LOAD <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read back
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RDATA <= '0;
        end else if (BUS.rd) begin
            if (BUS.addr == REG_CTRL) begin
                RDATA <= {27'h0, ctrl[4:0]};
            end else if (BUS.addr == REG_BANK) begin
                RDATA <= {19'h0, startup_group, 3'h0, startup_bank};
            end else if (BUS.addr == REG_STATUS) begin
                RDATA <= {27'h0, CARD_MISSING, TRIG_ERR, READY, state};
            end else if (BUS.addr == REG_COUNT) begin
                RDATA <= {17'h0, cnt1, 1'b0, cnt0};
            end else if (BUS.addr == REG_TIME0) begin
                RDATA <= {8'h0, cal.hour, cal.minute, cal.second};
            end else if (BUS.addr == REG_TIME1) begin
                RDATA <= {8'h0, cal.year, cal.month, cal.day};
            end else if (BUS.addr == REG_LASTIDX) begin
                RDATA <= {25'h0, IMG_SLOT};
            end else begin
                RDATA <= '0;
            end
        end else begin
            RDATA <= '0;
        end
    end
endmodule
`default_nettype wire

// ==== verification/tis_ctrl_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module tis_ctrl_monitor #(
    parameter int STORE = 100
) (
    input wire logic                        CLK,
    input wire logic                        RST_B,
    input wire tis_pkg::tis_bus_t           BUS,
    input wire logic                        TRIG,
    input wire logic                        MEAS_DONE,
    input wire logic                        READY,
    input wire logic                        TRIG_ERR,
    input wire logic                        MEAS_START,
    input wire logic                        IMG_WRITE,
    input wire logic [tis_pkg::IDX_W-1:0]   IMG_SLOT
);
    import tis_pkg::*;
    // ----------------------------------------
    // Trigger, error and store checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // Init phase keeps ready and error low, then ready comes up
    sequence s_init_quiet;
        (!READY && !TRIG_ERR)[*8];
    endsequence
    sequence s_ready_soon;
        ##[1:4] READY;
    endsequence
    a_init_quiet: assert property ($rose(RST_B) |-> s_init_quiet ##1 s_ready_soon)
        else $error("ready or error out of step after reset");
    a_start_needs_ready: assert property (MEAS_START |-> READY && TRIG)
        else $error("start without ready trigger");
    a_trig_taken: assert property (TRIG && READY |-> MEAS_START)
        else $error("ready trigger not started");
    a_busy_drop: assert property (MEAS_START |=> !READY)
        else $error("ready stayed up in measurement");
    a_err_raise: assert property ($rose(TRIG_ERR) |-> $past(TRIG && !READY))
        else $error("error raised without busy trigger");
    a_err_clear: assert property ($fell(TRIG_ERR) |-> $past(TRIG && READY) ||
        $past(BUS.wr && BUS.addr == REG_CTRL, 2))
        else $error("error dropped without accepted trigger");
    a_write_cause: assert property (IMG_WRITE |-> $past(MEAS_DONE))
        else $error("image write without finished measurement");
    a_slot_range: assert property (IMG_WRITE |-> IMG_SLOT < STORE)
        else $error("slot beyond store");
    a_done_ready: assert property (MEAS_DONE && !READY |=> READY)
        else $error("ready missing after measurement end");
endmodule
bind tis_ctrl tis_ctrl_monitor #(.STORE(STORE)) u_mon (.CLK(CLK), .RST_B(RST_B), .BUS(BUS), .TRIG(TRIG),
    .MEAS_DONE(MEAS_DONE), .READY(READY), .TRIG_ERR(TRIG_ERR), .MEAS_START(MEAS_START),
    .IMG_WRITE(IMG_WRITE), .IMG_SLOT(IMG_SLOT));
`default_nettype wire

// ==== verification/tis_far_end.sv ====
`timescale 1ns/1ns
`default_nettype none
module tis_far_end (
    input wire logic                        clk,
    input wire logic                        ready,
    input wire logic                        img_write,
    input wire logic [tis_pkg::IDX_W-1:0]   img_slot,
    output logic                            trig,
    output logic                            meas_done,
    output logic                            fail_verdict,
    output logic                            meas_cam
);
    import tis_pkg::*;
    logic               wrote;
    logic [IDX_W-1:0]   slot;
    // ----------------------------------------
    // External controller and measurement engine
    // ----------------------------------------
    initial begin
        trig = 1'b0;
        meas_done = 1'b0;
        fail_verdict = 1'b0;
        meas_cam = 1'b0;
    end
    // One measurement; poke repeats the trigger while busy
    task automatic measure(input logic fail, input logic cam, input logic poke, input int lat);
        int n;
        n = 0;
        @(posedge clk);
        #1;
        while (ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        @(posedge clk);
        trig <= 1'b1;
        meas_cam <= cam;
        @(posedge clk);
        trig <= poke;
        meas_cam <= ~cam;
        @(posedge clk);
        trig <= 1'b0;
        repeat (lat) @(posedge clk);
        meas_done <= 1'b1;
        fail_verdict <= fail;
        @(posedge clk);
        meas_done <= 1'b0;
        fail_verdict <= ~fail;
        #1 wrote = img_write;
        slot = img_slot;
    endtask
endmodule
`default_nettype wire

// ==== verification/test_trigger_image_store_ctrl.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_trigger_image_store_ctrl;
    import tis_pkg::*;
    logic               clk, rst_b, trig, meas_done, fail_verdict, meas_cam, bank_change, card_present;
    logic               ready, trig_err, meas_start, img_write, card_load, card_missing;
    tis_bus_t           bus;
    logic [31:0]        rdata, d;
    logic [IDX_W-1:0]   img_slot;
    logic [BANK_W-1:0]  active_bank;
    int                 miscompares, n_compared, cycles, starts;

    tis_ctrl uut (.CLK(clk), .RST_B(rst_b), .BUS(bus), .RDATA(rdata), .TRIG(trig), .CMD(1'b0),
        .MEAS_DONE(meas_done), .FAIL_VERDICT(fail_verdict), .MEAS_CAM(meas_cam), .BANK_CHANGE(bank_change),
        .CARD_PRESENT(card_present), .READY(ready), .TRIG_ERR(trig_err), .MEAS_START(meas_start),
        .IMG_WRITE(img_write), .IMG_SLOT(img_slot), .ACTIVE_BANK(active_bank), .CARD_LOAD(card_load),
        .CARD_MISSING(card_missing));
    tis_far_end far (.clk(clk), .ready(ready), .img_write(img_write), .img_slot(img_slot), .trig(trig),
        .meas_done(meas_done), .fail_verdict(fail_verdict), .meas_cam(meas_cam));
    // ----------------------------------------
    // Clock, start counter and timeout
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (meas_start === 1'b1) starts++;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end
    // ----------------------------------------
    // Bus and compare helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic do_reset(input logic [31:0] boot);
        int n;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 chk_bit(ready, 1'b0);
        if (boot != 32'h0) begin
            wr(REG_BANK, boot);
        end
        n = 0;
        while (ready !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1 n++;
        end
        chk_bit(trig_err, 1'b0);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        do_reset(32'h0);
        chk_reg(REG_CTRL, CTRL_RESET);
        chk_reg(REG_COUNT, 32'h0);
        chk({27'h0, active_bank}, {27'h0, BANK_RESET});
        chk_bit(card_missing, 1'b0);
        $display("reset test done");
    endtask
    // Startup bank and group written during init, card absent then present
    task automatic t_boot;
        do_reset(32'h0315);
        chk({27'h0, active_bank}, 32'h15);
        chk_bit(card_missing, 1'b1);
        chk_bit(card_load, 1'b0);
        card_present <= 1'b1;
        do_reset(32'h0315);
        chk_bit(card_load, 1'b1);
        chk_bit(card_missing, 1'b0);
        $display("startup test done");
    endtask
    task automatic t_keep;
        logic e;
        for (int m = 0; m < 3; m++) begin
            for (int f = 0; f < 2; f++) begin
                e = (m == 2) || (m == 1 && f == 1);
                wr(REG_CTRL, {28'h0, 2'b11, m[1:0]});
                wr(REG_CLEAR, 32'h1);
                far.measure(f[0], 1'b0, 1'b0, 2);
                chk_bit(far.wrote, e);
                chk_reg(REG_COUNT, {31'h0, e});
            end
        end
        $display("retention test done");
    endtask
    task automatic t_ring;
        wr(REG_CTRL, 32'he);
        wr(REG_CLEAR, 32'h1);
        for (int i = 0; i <= 100; i++) begin
            far.measure(1'b0, 1'b0, 1'b0, 1);
            chk({25'h0, far.slot}, i % 100);
        end
        chk_reg(REG_COUNT, 32'h64);
        do_reset(32'h0);
        chk_reg(REG_COUNT, 32'h0);
        $display("ring test done");
    endtask
    task automatic t_two;
        wr(REG_CTRL, 32'h1e);
        for (int i = 0; i <= 50; i++) begin
            far.measure(1'b0, 1'b1, 1'b0, 3);
            chk({25'h0, far.slot}, 50 + i % 50);
        end
        far.measure(1'b1, 1'b0, 1'b0, 1);
        chk({25'h0, far.slot}, 32'h0);
        chk_reg(REG_COUNT, 32'h3201);
        $display("two camera test done");
    endtask
    task automatic t_err;
        int s;
        s = starts;
        wr(REG_CLEAR, 32'h1);
        wr(REG_CTRL, 32'hc);
        far.measure(1'b0, 1'b0, 1'b1, 2);
        chk_bit(trig_err, 1'b1);
        chk(starts - s, 32'h1);
        far.measure(1'b0, 1'b0, 1'b0, 2);
        chk_bit(trig_err, 1'b0);
        far.measure(1'b0, 1'b0, 1'b1, 2);
        chk_bit(trig_err, 1'b1);
        wr(REG_CTRL, 32'h4);
        @(posedge clk);
        #1 chk_bit(trig_err, 1'b0);
        far.measure(1'b0, 1'b0, 1'b1, 2);
        chk_bit(trig_err, 1'b0);
        chk(starts - s, 32'h4);
        $display("trigger error test done");
    endtask
    task automatic t_clear;
        for (int k = 0; k < 2; k++) begin
            wr(REG_CTRL, k == 0 ? 32'he : 32'ha);
            far.measure(1'b0, 1'b0, 1'b0, 1);
            @(posedge clk);
            bank_change <= 1'b1;
            @(posedge clk);
            bank_change <= 1'b0;
            chk_reg(REG_COUNT, k);
        end
        wr(REG_CLEAR, 32'h1);
        chk_reg(REG_COUNT, 32'h0);
        chk_reg(REG_CTRL, 32'ha);
        $display("clear test done");
    endtask
    task automatic t_cal;
        wr(REG_TIME0, 32'h07332211);
        wr(REG_TIME0, 32'h02004400);
        chk_reg(REG_TIME0, 32'h00334411);
        wr(REG_TIME1, 32'h070a0503);
        wr(REG_TIME1, 32'h01000009);
        chk_reg(REG_TIME1, 32'h000a0509);
        chk_reg(4'h9, 32'h0);
        $display("calendar test done");
    endtask
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        bus = '0;
        bank_change = 1'b0;
        card_present = 1'b0;
        miscompares = 0;
        n_compared = 0;
        cycles = 0;
        starts = 0;
        t_reset();
        t_boot();
        t_keep();
        t_ring();
        t_two();
        t_err();
        t_clear();
        t_cal();
        end_of_test();
    end
endmodule
`default_nettype wire
